// ==== inc/tas_pkg.sv ====
// package: constants and types of the timer array clock and mode setup block
`default_nettype none
package tas_pkg;

  // ----------------------------------------
  // register indices, byte address = 4 * index
  // ----------------------------------------
  localparam logic [19:0] IDX_CLK_GATE = 20'hF00F2;
  localparam logic [19:0] IDX_MODE_LO = 20'hF0190;
  localparam logic [19:0] IDX_MODE_HI = 20'hF01C8;
  localparam logic [19:0] IDX_PRESCALE = 20'hF01B6;
  localparam logic [19:0] IDX_DATA = 20'hF0300;
  localparam logic [19:0] IDX_COUNT = 20'hF0320;
  localparam logic [19:0] IDX_START = 20'hF0340;
  localparam logic [19:0] IDX_STOP = 20'hF0341;
  localparam logic [19:0] IDX_RUN = 20'hF0342;

  // ----------------------------------------
  // field positions and sizes
  // ----------------------------------------
  localparam int GATE_UNIT_BIT = 0;
  localparam int GATE_INV_BIT = 1;
  localparam int NCH = 12;
  localparam int NLOW = 8;
  localparam int MODE_STEP = 2;
  localparam int FIELD_W = 4;
  localparam int DIV_W = 15;

  // ----------------------------------------
  // encodings
  // ----------------------------------------
  localparam logic [3:0] MD_INTERVAL = 4'h0;
  localparam logic [3:0] MD_CAPTURE = 4'h2;
  localparam logic [3:0] MD_EVENT = 4'h3;
  localparam logic [1:0] CCS_OPCLK = 2'h0;
  localparam logic [1:0] CCS_PIN = 2'h1;
  localparam logic [2:0] STS_EDGE = 3'h1;
  localparam logic [2:0] STS_BOTH = 3'h2;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef struct packed {
    logic op_clock_select;
    logic rsv14;
    logic count_clock_select_hi;
    logic count_clock_select_lo;
    logic master;
    logic [2:0] sts;
    logic edge_select_hi;
    logic edge_select_lo;
    logic rsv5;
    logic [4:0] md;
  } tas_mode_s;

  typedef struct packed {
    logic [19:0] idx;
    logic write;
    logic [2:0] size;
  } tas_req_s;

  typedef enum {BUS_IDLE, BUS_DATA} tas_bus_e;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0] GATE_RST = 8'h00;
  localparam logic [15:0] PRESCALE_RST = 16'h0000;
  localparam tas_mode_s MODE_RST = 16'h0000;
  localparam logic [15:0] DATA_RST = 16'h0000;
  localparam logic [15:0] COUNT_RST = 16'hFFFF;

endpackage
`default_nettype wire

// ==== design/tas_prescaler.sv ====
// module: shared operation clock enables divided from the system clock
`default_nettype none
module tas_prescaler #(
  parameter int DIV_W = tas_pkg::DIV_W
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  // control
  input wire logic i_clr,
  input wire logic [15:0] i_fields,
  // enables
  output logic [3:0] o_tick
);

  logic [DIV_W-1:0] div_reg;
  logic [DIV_W-1:0] div_next;

  // ----------------------------------------
  // free divider, held at zero while the unit is off
  // ----------------------------------------
  always_comb begin
    div_next = i_clr ? '0 : div_reg + 1'b1;
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_next;
    end
  end

  // one-cycle pulse every 2^k cycles; pulses, not clocks, keep channels in step
  for (genvar m = 0; m < 4; m++) begin : g_tick
    logic [DIV_W-1:0] mask;
    assign mask = DIV_W'((32'h1 << i_fields[m*tas_pkg::FIELD_W +: 4]) - 32'h1); // [R10]
    assign o_tick[m] = !i_clr && ((div_reg & mask) == mask); // [R20]
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  chk_div_by_one: assert property (@(posedge i_clk_sys) disable iff (!i_rstn) // [R10]
    (i_fields[3:0] == 4'h0 && !i_clr) |-> o_tick[0])
    else $error("undivided enable missing");

  chk_div_by_two: assert property (@(posedge i_clk_sys) disable iff (!i_rstn) // [R20]
    (i_fields[7:4] == 4'h1 && !i_clr && o_tick[1]) |=> !o_tick[1])
    else $error("halved enable ran two cycles");

endmodule // tas_prescaler
`default_nettype wire

// ==== design/tas_channel.sv ====
// module: one timer channel, counter and data register with capture
`default_nettype none
module tas_channel (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  // control
  input wire logic i_clr,
  input wire logic i_op_tick,
  input wire logic i_pin,
  input wire tas_pkg::tas_mode_s i_mode,
  input wire logic i_start,
  input wire logic i_stop,
  input wire logic i_data_we,
  input wire logic [15:0] i_wdata,
  // status
  output logic [15:0] o_data,
  output logic [15:0] o_count,
  output logic o_running,
  output logic o_irq
);

  logic [15:0] cnt_reg, cnt_next, dat_reg, dat_next;
  logic run_reg, run_next, irq_reg, irq_next, pin_reg;
  logic rise, fall, start_edge, cap_edge, tick, capture, hw_trig, both;

  assign rise = i_pin & ~pin_reg;
  assign fall = ~i_pin & pin_reg;
  assign capture = (i_mode.md[4:1] == tas_pkg::MD_CAPTURE);
  assign hw_trig = (i_mode.sts == tas_pkg::STS_EDGE) || both; // [R2]
  assign both = (i_mode.sts == tas_pkg::STS_BOTH);

  // ----------------------------------------
  // valid edge choice
  // ----------------------------------------
  always_comb begin
    unique case ({i_mode.edge_select_hi, i_mode.edge_select_lo}) // [R2]
      2'h0: begin start_edge = fall; cap_edge = fall; end
      2'h1: begin start_edge = rise; cap_edge = rise; end
      2'h2: begin start_edge = fall; cap_edge = rise; end
      2'h3: begin start_edge = rise; cap_edge = fall; end
    endcase
  end

  // count clock; master-fed selections give no count tick here
  always_comb begin
    unique case ({i_mode.count_clock_select_hi, i_mode.count_clock_select_lo}) // [R18]
      tas_pkg::CCS_OPCLK: tick = i_op_tick;
      tas_pkg::CCS_PIN: tick = start_edge;
      default: tick = 1'b0;
    endcase
  end

  // ----------------------------------------
  // counter, data register and interrupt
  // ----------------------------------------
  always_comb begin
    cnt_next = cnt_reg;
    dat_next = dat_reg;
    run_next = run_reg;
    irq_next = 1'b0;
    if (i_data_we) dat_next = i_wdata;
    if (i_start) begin
      run_next = 1'b1;
      cnt_next = capture ? 16'h0000 : dat_reg;
      irq_next = i_mode.md[0];
    end else if (i_stop) begin
      run_next = 1'b0;
    end else if (run_reg) begin
      if (capture && hw_trig && cap_edge) begin
        dat_next = cnt_reg; // [R1]
        cnt_next = 16'h0000;
        irq_next = 1'b1;
      end else if (capture && both && start_edge) begin
        cnt_next = 16'h0000; // width measurement restarts on the start edge
      end else if (tick) begin
        if (capture) begin
          cnt_next = cnt_reg + 16'h0001;
        end else if (cnt_reg == 16'h0000) begin
          cnt_next = dat_reg; // [R19]
          irq_next = 1'b1;
        end else begin
          cnt_next = cnt_reg - 16'h0001;
        end
      end
    end
    if (i_clr) begin
      cnt_next = tas_pkg::COUNT_RST; // [R5]
      dat_next = tas_pkg::DATA_RST;
      run_next = 1'b0;
      irq_next = 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_reg <= tas_pkg::COUNT_RST;
      dat_reg <= tas_pkg::DATA_RST;
      run_reg <= 1'b0;
      irq_reg <= 1'b0;
      pin_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      dat_reg <= dat_next;
      run_reg <= run_next;
      irq_reg <= irq_next;
      pin_reg <= i_pin;
    end
  end

  assign o_data = dat_reg;
  assign o_count = cnt_reg;
  assign o_running = run_reg;
  assign o_irq = irq_reg;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);

  chk_capture_copy: assert property ( // [R1]
    (run_reg && capture && hw_trig && cap_edge && !i_start && !i_stop && !i_clr)
    |=> (dat_reg == $past(cnt_reg)) && (cnt_reg == 16'h0000) && irq_reg)
    else $error("capture did not copy the counter");

  chk_compare_wrap: assert property ( // [R19]
    (run_reg && !capture && tick && cnt_reg == 16'h0000 && !i_start && !i_stop && !i_clr)
    |=> irq_reg && (cnt_reg == $past(dat_reg)))
    else $error("compare expiry without reload or interrupt");

  chk_clear_hold: assert property ( // [R5]
    i_clr |=> (cnt_reg == tas_pkg::COUNT_RST) && !run_reg && !irq_reg)
    else $error("channel not held in reset");

endmodule // tas_channel
`default_nettype wire

// ==== design/tas_top.sv ====
// module: timer array clock gate, prescaler and mode registers on AHB-Lite
// Operation
// [R1] On a capture trigger the data register takes the current counter value.
// [R2] The capture trigger is a valid input pin edge chosen in the mode register.
// [R3] Software sets the unit clock enable before touching any channel.
// [R4] With the unit clock off, timer writes are dropped and reads give defaults.
// [R5] Unit clock off stops the clock and holds the whole array in reset.
// [R6] Gate bit 1 clocks the inverter block; at 0 that block is in reset.
// [R7] Software writes zeros to gate bits 2 to 7.
// [R8] The gate register takes byte or bit writes and resets to zero.
// [R9] Shared clocks a and b feed channels 0 to 7, c and d channels 8 to 11.
// [R10] Each shared clock is the system clock divided by two to the field value.
// [R11] Software changes a prescale field only while its users are stopped.
// [R12] The prescaler register is written as one 16-bit access, nibble per clock.
// [R13] Software stops all channels before changing the system clock source.
// [R14] Software rewrites a mode register only while its channel is stopped.
// [R15] The mode register selects clocks, role, triggers, edge and operation mode; the master bit is stored but drives no logic here.
// [R16] Operation clock select 0 picks clock a for low, clock c for high channels.
// [R17] Operation clock select 1 picks clock b for low, clock d for high channels.
// [R18] Count clock select picks operation clock, pin edge, or master sources; master selections give no count tick here.
// [R19] In compare use the counter counts down and interrupts on reaching zero.
// [R20] Divided clocks are one-cycle enables in the system clock domain.
`default_nettype none
module tas_top #(
  parameter int NCH = tas_pkg::NCH
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  // AHB-Lite slave
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  // timer input pins
  input wire logic [11:0] i_tin,
  // channel interrupts and inverter block gate
  output logic [11:0] o_irq,
  output logic o_inv_block_on
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  tas_pkg::tas_bus_e phase_reg, phase_next;
  tas_pkg::tas_req_s req_reg, req_next;
  logic hready_reg, hready_next, hresp_reg;
  logic [31:0] rdata_reg, rdata_next, rd_val;
  logic [7:0] gate_reg, gate_next;
  logic [15:0] pre_reg, pre_next;
  tas_pkg::tas_mode_s mode_reg [NCH];
  tas_pkg::tas_mode_s mode_next [NCH];
  logic [11:0] tin_s1_reg, tin_s2_reg;
  logic [11:0] start_pls, stop_pls, data_we, running, op_tick, irq_w;
  logic [15:0] data_rd [NCH];
  logic [15:0] count_rd [NCH];
  logic [3:0] tick;
  logic unit_on, wr;

  assign unit_on = gate_reg[tas_pkg::GATE_UNIT_BIT];
  assign wr = (phase_reg == tas_pkg::BUS_DATA) && req_reg.write;

  // mode register index: low group then high group, two apart
  function automatic logic [19:0] mode_idx(input int n);
    if (n < tas_pkg::NLOW) begin
      return tas_pkg::IDX_MODE_LO + 20'(tas_pkg::MODE_STEP * n);
    end
    return tas_pkg::IDX_MODE_HI + 20'(tas_pkg::MODE_STEP * (n - tas_pkg::NLOW));
  endfunction

  // ----------------------------------------
  // pin synchroniser
  // ----------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      tin_s1_reg <= 12'h000;
      tin_s2_reg <= 12'h000;
    end else begin
      tin_s1_reg <= i_tin;
      tin_s2_reg <= tin_s1_reg;
    end
  end

  // ----------------------------------------
  // read mux, unmapped words read zero
  // ----------------------------------------
  always_comb begin
    rd_val = 32'h0000_0000;
    if (req_reg.idx == tas_pkg::IDX_CLK_GATE) rd_val = {24'h00_0000, gate_reg};
    if (req_reg.idx == tas_pkg::IDX_PRESCALE) rd_val = {16'h0000, pre_reg};
    if (req_reg.idx == tas_pkg::IDX_RUN) rd_val = {20'h0_0000, running};
    for (int n = 0; n < NCH; n++) begin
      if (req_reg.idx == mode_idx(n)) rd_val = {16'h0000, mode_reg[n]};
      if (req_reg.idx == tas_pkg::IDX_DATA + 20'(n)) rd_val = {16'h0000, data_rd[n]};
      if (req_reg.idx == tas_pkg::IDX_COUNT + 20'(n)) rd_val = {16'h0000, count_rd[n]};
    end
  end

  // ----------------------------------------
  // bus phases and register writes
  // ----------------------------------------
  // one wait state lets read data come straight from a flop
  always_comb begin
    phase_next = phase_reg;
    req_next = req_reg;
    hready_next = hready_reg;
    rdata_next = rdata_reg;
    gate_next = gate_reg;
    pre_next = pre_reg;
    mode_next = mode_reg;
    start_pls = 12'h000;
    stop_pls = 12'h000;
    data_we = 12'h000;
    unique case (phase_reg)
      tas_pkg::BUS_IDLE: begin
        if (i_hsel && i_htrans[1] && i_hready) begin
          req_next = '{idx: i_haddr[21:2], write: i_hwrite, size: i_hsize};
          phase_next = tas_pkg::BUS_DATA;
          hready_next = 1'b0;
        end
      end
      tas_pkg::BUS_DATA: begin
        phase_next = tas_pkg::BUS_IDLE;
        hready_next = 1'b1;
        rdata_next = req_reg.write ? 32'h0000_0000 : rd_val;
      end
    endcase
    if (wr && req_reg.idx == tas_pkg::IDX_CLK_GATE) begin
      gate_next = i_hwdata[7:0]; // [R8]
    end else if (wr && unit_on) begin // [R4]
      if (req_reg.idx == tas_pkg::IDX_PRESCALE && req_reg.size != 3'h0) begin
        pre_next = i_hwdata[15:0]; // [R12]
      end
      if (req_reg.idx == tas_pkg::IDX_START) start_pls = i_hwdata[11:0];
      if (req_reg.idx == tas_pkg::IDX_STOP) stop_pls = i_hwdata[11:0];
      for (int n = 0; n < NCH; n++) begin
        if (req_reg.idx == mode_idx(n)) begin
          mode_next[n] = tas_pkg::tas_mode_s'(i_hwdata[15:0]); // [R15]
          mode_next[n].rsv14 = 1'b0;
          mode_next[n].rsv5 = 1'b0;
        end
        data_we[n] = (req_reg.idx == tas_pkg::IDX_DATA + 20'(n));
      end
    end
    if (!unit_on) begin
      pre_next = tas_pkg::PRESCALE_RST; // [R5]
      mode_next = '{default: tas_pkg::MODE_RST};
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      phase_reg <= tas_pkg::BUS_IDLE;
      req_reg <= '0;
      hready_reg <= 1'b1;
      hresp_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      gate_reg <= tas_pkg::GATE_RST; // [R8]
      pre_reg <= tas_pkg::PRESCALE_RST;
      mode_reg <= '{default: tas_pkg::MODE_RST};
    end else begin
      phase_reg <= phase_next;
      req_reg <= req_next;
      hready_reg <= hready_next;
      hresp_reg <= 1'b0;
      rdata_reg <= rdata_next;
      gate_reg <= gate_next;
      pre_reg <= pre_next;
      mode_reg <= mode_next;
    end
  end

  // ----------------------------------------
  // shared clocks and channels
  // ----------------------------------------
  tas_prescaler #(.DIV_W(tas_pkg::DIV_W)) u_prescaler (
    .i_clk_sys(i_clk_sys),
    .i_rstn(i_rstn),
    .i_clr(!unit_on),
    .i_fields(pre_reg),
    .o_tick(tick)
  );

  for (genvar n = 0; n < NCH; n++) begin : g_ch
    // low channels see only a and b, high channels only c and d
    if (n < tas_pkg::NLOW) begin : g_low
      assign op_tick[n] = mode_reg[n].op_clock_select ? tick[1] : tick[0]; // [R9] [R16] [R17]
    end else begin : g_high
      assign op_tick[n] = mode_reg[n].op_clock_select ? tick[3] : tick[2]; // [R9] [R16] [R17]
    end
    tas_channel u_ch (
      .i_clk_sys(i_clk_sys),
      .i_rstn(i_rstn),
      .i_clr(!unit_on),
      .i_op_tick(op_tick[n]),
      .i_pin(tin_s2_reg[n]),
      .i_mode(mode_reg[n]),
      .i_start(start_pls[n]),
      .i_stop(stop_pls[n]),
      .i_data_we(data_we[n]),
      .i_wdata(i_hwdata[15:0]),
      .o_data(data_rd[n]),
      .o_count(count_rd[n]),
      .o_running(running[n]),
      .o_irq(irq_w[n])
    );
  end

  // ----------------------------------------
  // outputs, all from flops
  // ----------------------------------------
  assign o_hrdata = rdata_reg;
  assign o_hreadyout = hready_reg;
  assign o_hresp = hresp_reg;
  assign o_irq = irq_w;
  assign o_inv_block_on = gate_reg[tas_pkg::GATE_INV_BIT]; // [R6]

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);

  sequence seq_addr_taken;
    (phase_reg == tas_pkg::BUS_IDLE) && i_hsel && i_htrans[1] && i_hready;
  endsequence

  sequence seq_one_wait;
    !o_hreadyout ##1 o_hreadyout;
  endsequence

  chk_bus_one_wait: assert property (seq_addr_taken |=> seq_one_wait) // [R8]
    else $error("bus answer not after one wait state");

  chk_gate_write: assert property ( // [R8]
    (wr && req_reg.idx == tas_pkg::IDX_CLK_GATE) |=> gate_reg == $past(i_hwdata[7:0]))
    else $error("gate register missed a write");

  chk_write_ignored: assert property ( // [R4]
    (wr && !unit_on && req_reg.idx == tas_pkg::IDX_PRESCALE)
    |=> pre_reg == tas_pkg::PRESCALE_RST)
    else $error("prescaler written while unit off");

  // any channel's counter word, not only the first one
  chk_read_default: assert property ( // [R4]
    (phase_reg == tas_pkg::BUS_DATA && !req_reg.write && !unit_on
     && req_reg.idx >= tas_pkg::IDX_COUNT
     && req_reg.idx < tas_pkg::IDX_COUNT + 20'(NCH))
    |=> o_hrdata == {16'h0000, tas_pkg::COUNT_RST})
    else $error("counter read not default while unit off");

  chk_prescale_half: assert property ( // [R12]
    (wr && unit_on && req_reg.size == 3'h0 && req_reg.idx == tas_pkg::IDX_PRESCALE)
    |=> $stable(pre_reg))
    else $error("byte write changed the prescaler");

  chk_group_low: assert property ( // [R9]
    (tick[2] && !tick[0] && !tick[1]) |-> !op_tick[0])
    else $error("low channel took a high group clock");

  chk_unit_off: assert property ( // [R5]
    !unit_on |=> (mode_reg[0] == tas_pkg::MODE_RST) && !running[0])
    else $error("array not held in reset");

endmodule // tas_top
`default_nettype wire

// ==== dv/test_tas_top.sv ====
// testbench: register access, clock division and capture checks of the timer setup block
`default_nettype none
module test_tas_top;
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------
  // signals and bookkeeping
  // ----------------------------------------
  logic i_clk_sys = 1'b0;
  logic i_rstn = 1'b0;
  logic i_hsel = 1'b0;
  logic [31:0] i_haddr = 32'h0;
  logic [1:0] i_htrans = 2'h0;
  logic i_hwrite = 1'b0;
  logic [2:0] i_hsize = 3'h2;
  logic [31:0] i_hwdata = 32'h0;
  logic [11:0] i_tin = 12'hFFF;
  logic [31:0] o_hrdata;
  logic o_hreadyout;
  logic o_hresp;
  logic [11:0] o_irq;
  logic o_inv_block_on;
  int fails = 0;
  int cmp_count = 0;
  int seed = 91804;
  int gap = 0;
  logic rd_ph = 1'b0;
  logic [31:0] rq[$];
  logic [27:0] pq[$];
  logic [31:0] r;

  tas_top u_tas_top (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_hsel(i_hsel),
    .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(i_hsize),
    .i_hwdata(i_hwdata), .i_hready(o_hreadyout), .o_hrdata(o_hrdata),
    .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .i_tin(i_tin), .o_irq(o_irq),
    .o_inv_block_on(o_inv_block_on));

  // 10 MHz system clock
  initial begin
    forever #50 i_clk_sys = ~i_clk_sys;
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    // a read whose answer never came counts as a mismatch
    if (rq.size() != 0) fails++;
    if (fails == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic hang();
    fails++;
    wrap_up();
  endtask

  // the master never assumes a latency, it waits for hready under a bound
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge i_clk_sys);
      n++;
      if (n > 50) hang();
    end while (o_hreadyout !== 1'b1);
  endtask

  task automatic bus(input logic w, input logic [19:0] idx, input logic [2:0] sz,
                     input logic [31:0] d);
    i_hsel <= 1'b1;
    i_htrans <= 2'h2;
    i_haddr <= {10'h0, idx, 2'h0};
    i_hwrite <= w;
    i_hsize <= sz;
    wait_rdy();
    i_htrans <= 2'h0;
    i_hsel <= 1'b0;
    i_hwdata <= d;
    wait_rdy();
  endtask

  task automatic wr(input logic [19:0] idx, input logic [31:0] d);
    bus(1'b1, idx, 3'h2, d);
  endtask

  // the expected word is noted before the read is issued
  task automatic rd(input logic [19:0] idx, input logic [31:0] exp);
    rq.push_back(exp);
    bus(1'b0, idx, 3'h2, 32'h0);
  endtask

  function automatic logic [19:0] mix(input int ch);
    if (ch < 8) return tas_pkg::IDX_MODE_LO + 20'(2 * ch);
    return tas_pkg::IDX_MODE_HI + 20'(2 * (ch - 8));
  endfunction

  // interval run on one channel: irq spacing is (n + 1) ticks of the chosen shared clock
  task automatic run_ch(input int ch, input logic cks, input int k);
    tas_pkg::tas_mode_s m;
    logic [15:0] n;
    int t;
    m = tas_pkg::MODE_RST;
    m.op_clock_select = cks;
    n = 16'(1 + ($random(seed) & 7));
    wr(tas_pkg::IDX_DATA + 20'(ch), {16'h0, n});
    wr(mix(ch), {16'h0, m});
    wr(tas_pkg::IDX_START, 32'h1 << ch);
    rd(tas_pkg::IDX_RUN, 32'h1 << ch);
    t = 0;
    do begin
      @(negedge i_clk_sys);
      t++;
      if (t > 3000) hang();
    end while (o_irq === 12'h0);
    // first pulse has an unknown tick phase, so only later spacings are noted
    @(negedge i_clk_sys);
    repeat (2) pq.push_back({12'h1 << ch, 16'((n + 16'h1) << k)});
    t = 0;
    while (pq.size() > 0) begin
      @(negedge i_clk_sys);
      t++;
      if (t > 3000) hang();
    end
    @(posedge i_clk_sys);
    wr(tas_pkg::IDX_STOP, 32'h1 << ch);
    rd(tas_pkg::IDX_RUN, 32'h0);
  endtask

  // ----------------------------------------
  // output watcher: read data and irq spacing
  // ----------------------------------------
  always @(posedge i_clk_sys) begin
    if (rd_ph && o_hreadyout === 1'b1 && rq.size() > 0) begin
      check(o_hrdata, rq.pop_front());
    end
    if (o_hreadyout === 1'b1) begin
      rd_ph = i_hsel & i_htrans[1] & ~i_hwrite;
    end
    if (o_irq !== 12'h0) begin
      if (pq.size() > 0) begin
        check({4'h0, o_irq, 16'(gap + 1)}, {4'h0, pq.pop_front()});
      end
      gap = 0;
    end else begin
      gap++;
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    tas_pkg::tas_mode_s m;
    repeat (4) @(posedge i_clk_sys);
    i_rstn <= 1'b1;
    @(posedge i_clk_sys);
    rd(tas_pkg::IDX_CLK_GATE, 32'h0);
    rd(tas_pkg::IDX_PRESCALE, 32'h0);
    wr(mix(0), 32'hFFFF);
    rd(mix(0), 32'h0);
    // unit clock on before any channel is set up, upper gate bits kept zero
    bus(1'b1, tas_pkg::IDX_CLK_GATE, 3'h0, 32'h03);
    rd(tas_pkg::IDX_CLK_GATE, 32'h03);
    check({31'h0, o_inv_block_on}, 32'h1);
    // distinct divisors per shared clock show which one a channel uses
    wr(tas_pkg::IDX_PRESCALE, 32'h3210);
    bus(1'b1, tas_pkg::IDX_PRESCALE, 3'h0, 32'hFF);
    rd(tas_pkg::IDX_PRESCALE, 32'h3210);
    r = $random(seed);
    wr(mix(11), r);
    rd(mix(11), {16'h0, r[15:0] & 16'hBFDF});
    wr(mix(11), 32'h0);
    rd(20'h00010, 32'h0);
    run_ch(0, 1'b0, 0);
    run_ch(0, 1'b1, 1);
    run_ch(8, 1'b0, 2);
    run_ch(8, 1'b1, 3);
    // unit clock off holds the whole array in reset and drops timer writes
    bus(1'b1, tas_pkg::IDX_CLK_GATE, 3'h0, 32'h02);
    wr(tas_pkg::IDX_PRESCALE, 32'h5555);
    rd(mix(8), 32'h0);
    rd(tas_pkg::IDX_PRESCALE, 32'h0);
    rd(tas_pkg::IDX_COUNT + 20'h8, 32'hFFFF);
    check({31'h0, o_inv_block_on}, 32'h1);
    wr(mix(0), 32'hFFFF);
    bus(1'b1, tas_pkg::IDX_CLK_GATE, 3'h0, 32'h03);
    rd(mix(0), 32'h0);
    // capture: falling edge starts and clears, rising edge captures, clock a very slow
    wr(tas_pkg::IDX_PRESCALE, 32'h000F);
    wr(tas_pkg::IDX_DATA + 20'h1, 32'hABCD);
    m = tas_pkg::MODE_RST;
    m.md = 5'h04;
    m.sts = tas_pkg::STS_BOTH;
    m.edge_select_hi = 1'b1;
    wr(mix(1), {16'h0, m});
    wr(tas_pkg::IDX_START, 32'h2);
    i_tin[1] <= 1'b0;
    repeat (8) @(posedge i_clk_sys);
    rd(tas_pkg::IDX_DATA + 20'h1, 32'hABCD);
    i_tin[1] <= 1'b1;
    repeat (8) @(posedge i_clk_sys);
    rd(tas_pkg::IDX_DATA + 20'h1, 32'h0);
    // every channel stopped before the unit is switched off
    wr(tas_pkg::IDX_STOP, 32'hFFF);
    rd(tas_pkg::IDX_RUN, 32'h0);
    bus(1'b1, tas_pkg::IDX_CLK_GATE, 3'h0, 32'h00);
    check({31'h0, o_inv_block_on}, 32'h0);
    wrap_up();
  end
endmodule // test_tas_top
`default_nettype wire
